// ### include/mcudp_pkg.sv
// package for the microcontroller core datapath
// assumes one instruction-cycle clock and a synchronous active-high reset
package mcudp_pkg;

	// --------------------------------------------------------------
	// sizes and reset values
	// --------------------------------------------------------------
	localparam int          MCUDP_PTR_W       = 11;
	localparam int          MCUDP_STACK_DEPTH = 3;
	localparam logic [10:0] MCUDP_PTR_RESET   = 11'h000;
	localparam logic [10:0] MCUDP_IRQ_VECTOR  = 11'h0FF;
	localparam logic [3:0]  MCUDP_EN_RESET    = 4'h0;
	localparam logic [7:0]  MCUDP_TIMER_RESET = 8'h00;
	localparam logic        MCUDP_GATE_RESET  = 1'b1;

	// --------------------------------------------------------------
	// feature enable bit positions
	// --------------------------------------------------------------
	localparam int MCUDP_EN_COUNTER = 0;
	localparam int MCUDP_EN_IRQ     = 1;
	localparam int MCUDP_EN_DRIVE   = 2;
	localparam int MCUDP_EN_SO      = 3;

	// --------------------------------------------------------------
	// datapath operations issued by the sequencer
	// --------------------------------------------------------------
	typedef enum logic [4:0] {
		MCUDP_OP_NOP       = 5'h00,
		MCUDP_OP_JUMP      = 5'h01,
		MCUDP_OP_CALL      = 5'h02,
		MCUDP_OP_RET       = 5'h03,
		MCUDP_OP_ADD       = 5'h04,
		MCUDP_OP_ADDC      = 5'h05,
		MCUDP_OP_AND       = 5'h06,
		MCUDP_OP_XOR       = 5'h07,
		MCUDP_OP_LOADA     = 5'h08,
		MCUDP_OP_LOADROW   = 5'h09,
		MCUDP_OP_LOADDIG   = 5'h0A,
		MCUDP_OP_DIGOUT    = 5'h0B,
		MCUDP_OP_SWAPSER   = 5'h0C,
		MCUDP_OP_LOADEN    = 5'h0D,
		MCUDP_OP_TIMERLD   = 5'h0E,
		MCUDP_OP_LATCHLO   = 5'h0F,
		MCUDP_OP_LATCHHI   = 5'h10,
		MCUDP_OP_LATCHROM  = 5'h11,
		MCUDP_OP_PORTRD_LO = 5'h12,
		MCUDP_OP_PORTRD_HI = 5'h13,
		MCUDP_OP_QUADWR    = 5'h14
	} mcudp_op_e;

endpackage

// ### verilog/mcudp_core.sv
// core datapath of a small 4-bit microcontroller: pointer, stack, ram pointer,
// accumulator, timer, serial register, output latch and port drivers
// assumes a sequencer on clk_sys issues one operation per instruction cycle;
// pins from outside pass a two-stage synchroniser before use
//
// Operation
// RULE1: 11-bit instruction pointer steps by one each cycle unless control transfers.
// RULE2: three-entry return stack; call or interrupt pushes next address, return pops.
// RULE3: large variant ram pointer is 7 bits: 3 row bits, 4 digit bits.
// RULE4: small variant ram pointer is 6 bits: 2 row bits, 4 digit bits.
// RULE5: digit field of ram pointer is the source for the digit output register.
// RULE6: 4-bit adder writes the accumulator; carry out stored in carry flag.
// RULE7: 8-bit up timer loadable and readable, flags overflow on wrap, reset clears.
// RULE8: host option turns three general inputs into read, select and write strobes.
// RULE9: in dual clock use digit output bit 0 selects the clock source.
// RULE10: 8-bit latch from ram, accumulator or rom drives port; host write loads it.
// RULE11: port pin levels readable into accumulator and addressed ram digit.
// RULE12: accumulator-serial swap also copies carry into clock gate latch.
// RULE13: serial register swaps with accumulator in either mode.
// RULE14: 4-bit feature enable register written by load-enable-immediate, one feature per bit.
// RULE15: counter mode decrements serial register on each falling serial pulse of two cycles.
// RULE16: counter mode: serial clock pin shows gate latch, serial out shows bit 3.
// RULE17: shift mode: serial register shifts left each cycle, serial input into bit 0.
// RULE18: shift mode: serial clock pin is gate latch AND instruction clock.
// RULE19: enable bit 1 allows interrupts and is cleared when one is taken.
// RULE20: enable bit 2 drives the port from the latch; clear leaves it high impedance. The code also drives the port during a host read while the bit is clear.
// RULE21: shift mode: bit 3 routes serial msb to serial out, else out is 0.
// RULE22: host option fixes quad port bit 0 as an output to the host.
// RULE23: interrupt pushes next address, drops oldest entry, jumps to vector, clears enable.
// RULE24: host ready bit is cleared by every host write pulse.
// RULE25: reset clears pointer, acc, ram pointer, carry, digits, enables, timer, port; sets gate.
// RULE26: serial input synchronised and falling edge found from two samples.
`timescale 1ns/10ps

module mcudp_core
	import mcudp_pkg::*;
#(
	parameter int ROW_W     = 3,                     // 3 large variant, 2 small variant
	parameter bit HOST_BUS  = 1'b0,                  // host strobe option
	parameter bit DUAL_CLK  = 1'b0                   // dual clock option
)
(
	input  wire logic             clk_sys,           // instruction cycle clock
	input  wire logic             rst,               // synchronous reset, high
	input  wire mcudp_op_e        op,                // datapath operation this cycle
	input  wire logic [10:0]      op_target,         // jump or call target
	input  wire logic [7:0]       op_imm,            // immediate or rom data
	input  wire logic [3:0]       ram_rdata,         // addressed ram digit
	input  wire logic             irq_req,           // interrupt request from sequencer
	output logic      [10:0]      instr_pointer,     // program memory address
	output logic      [ROW_W-1:0] ram_row_select,    // ram row
	output logic      [3:0]       ram_digit_select,  // ram digit
	output logic                  ram_we,            // ram write strobe
	output logic      [3:0]       ram_wdata,         // ram write data
	output logic      [3:0]       acc,               // accumulator
	output logic                  carry,             // carry flag
	output logic      [7:0]       timer,             // up timer
	output logic                  timer_ovf,         // sticky overflow flag
	output logic                  irq_taken,         // one-cycle interrupt accept
	input  wire logic [3:0]       general_inputs,    // general inputs, async
	input  wire logic [7:0]       octal_io_port_in,  // port pin levels, async
	output logic      [7:0]       octal_io_port_out, // port drive value
	output logic      [7:0]       octal_io_port_oe,  // port drive enable
	input  wire logic [3:0]       quad_io_port_in,   // quad pin levels, async
	output logic      [3:0]       quad_io_port_out,  // quad drive value
	output logic      [3:0]       quad_io_port_oe,   // quad drive enable
	output logic      [3:0]       digit_output_port, // digit outputs
	output logic                  clock_source_select, // oscillator choice
	input  wire logic             serial_in,         // serial or counter input, async
	output logic                  serial_out,        // serial output
	output logic                  serial_clock_pin,  // serial clock output
	output logic                  host_rd_n,         // host read strobe, active low
	output logic                  host_ready_out     // ready to host
);

	// --------------------------------------------------------------
	// elaboration checks
	// --------------------------------------------------------------
	if (ROW_W != 2 && ROW_W != 3)
		$error("mcudp_core: ROW_W must be 2 or 3");
	if (MCUDP_STACK_DEPTH != 3 || MCUDP_PTR_W != 11)
		$error("mcudp_core: stack depth 3 and pointer width 11 are built in");

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef struct packed {
		logic [10:0]      ptr;
		logic [2:0][10:0] stack;
		logic [ROW_W-1:0] row;
		logic [3:0]       digit;
		logic [3:0]       acc;
		logic             carry;
		logic [7:0]       timer;
		logic             ovf;
		logic [3:0]       en;
		logic [3:0]       serial_shift_reg;
		logic             gate;
		logic [7:0]       latch;
		logic [3:0]       dout;
		logic [3:0]       quad;
		logic             ready;
		logic             so;
		logic             irq;
		logic [1:0]       si_sync;
		logic             si_prev;
		logic [3:0]       in_s1;
		logic [3:0]       in_s2;
		logic [7:0]       port_s1;
		logic [7:0]       port_s2;
		logic [3:0]       quad_s1;
		logic [3:0]       quad_s2;
		logic             wr_prev;
	} mcudp_state_s;

	mcudp_state_s st_reg;
	mcudp_state_s st_next;

	// --------------------------------------------------------------
	// helper functions
	// --------------------------------------------------------------
	// select a nibble of a byte
	function automatic logic [3:0] mcudp_nib(input logic [7:0] b, input logic hi);
		mcudp_nib = hi ? b[7:4] : b[3:0];
	endfunction

	// host strobe decode: select low and the given strobe line low, option only
	function automatic logic mcudp_strobe(input logic [3:0] lines, input logic [1:0] idx);
		mcudp_strobe = HOST_BUS && !lines[2] && !lines[idx];
	endfunction

	// --------------------------------------------------------------
	// next-state logic
	// --------------------------------------------------------------
	logic [4:0]  sum;
	logic        host_wr;
	logic        host_wr_fall;
	logic        si_fall;
	logic [10:0] ptr_inc;

	always_comb
	begin
		st_next      = st_reg;
		ram_we       = 1'b0;
		ram_wdata    = 4'h0;
		sum          = 5'h00;
		ptr_inc      = st_reg.ptr + 11'h001;
		// pin synchronisers, first stage read only by second
		st_next.in_s1   = general_inputs;
		st_next.in_s2   = st_reg.in_s1;
		st_next.port_s1 = octal_io_port_in;
		st_next.port_s2 = st_reg.port_s1;
		st_next.quad_s1 = quad_io_port_in;
		st_next.quad_s2 = st_reg.quad_s1;
		st_next.si_sync = {st_reg.si_sync[0], serial_in};
		st_next.si_prev = st_reg.si_sync[1];
		// host strobes taken from general inputs
		host_wr      = mcudp_strobe(st_reg.in_s2, 2'h3);   // RULE8
		host_wr_fall = host_wr && !st_reg.wr_prev;
		st_next.wr_prev = host_wr;
		si_fall      = st_reg.si_prev && !st_reg.si_sync[1]; // RULE26
		st_next.irq  = 1'b0;

		// pointer stepping and control transfer
		st_next.ptr = ptr_inc;                              // RULE1
		if (irq_req && st_reg.en[MCUDP_EN_IRQ])
		begin
			st_next.stack = {st_reg.stack[1:0], ptr_inc};   // RULE23
			st_next.ptr   = MCUDP_IRQ_VECTOR;               // RULE23
			st_next.irq   = 1'b1;
		end
		else
		begin
			case (op)
				MCUDP_OP_JUMP:
					st_next.ptr = op_target;                // RULE1
				MCUDP_OP_CALL:
				begin
					st_next.stack = {st_reg.stack[1:0], ptr_inc}; // RULE2
					st_next.ptr   = op_target;
				end
				MCUDP_OP_RET:
				begin
					st_next.ptr   = st_reg.stack[0];        // RULE2
					st_next.stack = {st_reg.stack[2], st_reg.stack[2:1]};
				end
				MCUDP_OP_ADD, MCUDP_OP_ADDC:
				begin
					sum = {1'b0, st_reg.acc} + {1'b0, ram_rdata}
						+ {4'h0, (op == MCUDP_OP_ADDC) & st_reg.carry};
					st_next.acc   = sum[3:0];               // RULE6
					st_next.carry = sum[4];                 // RULE6
				end
				MCUDP_OP_AND:
					st_next.acc = st_reg.acc & ram_rdata;   // RULE6
				MCUDP_OP_XOR:
					st_next.acc = st_reg.acc ^ ram_rdata;   // RULE6
				MCUDP_OP_LOADA:
					st_next.acc = op_imm[3:0];
				MCUDP_OP_LOADROW:
					st_next.row = op_imm[ROW_W-1:0];        // RULE3 RULE4
				MCUDP_OP_LOADDIG:
					st_next.digit = op_imm[3:0];            // RULE3 RULE4
				MCUDP_OP_DIGOUT:
					st_next.dout = st_reg.digit;            // RULE5
				MCUDP_OP_LOADEN:
					st_next.en = op_imm[3:0];               // RULE14
				MCUDP_OP_TIMERLD:
					st_next.timer = {ram_rdata, st_reg.acc}; // RULE7
				MCUDP_OP_LATCHLO:
					st_next.latch = {ram_rdata, st_reg.acc}; // RULE10
				MCUDP_OP_LATCHHI:
					st_next.latch = {st_reg.acc, ram_rdata}; // RULE10
				MCUDP_OP_LATCHROM:
					st_next.latch = op_imm;                 // RULE10
				MCUDP_OP_PORTRD_LO, MCUDP_OP_PORTRD_HI:
				begin
					st_next.acc = mcudp_nib(st_reg.port_s2, 1'b0); // RULE11
					ram_we      = 1'b1;
					ram_wdata   = mcudp_nib(st_reg.port_s2, 1'b1); // RULE11
				end
				MCUDP_OP_QUADWR:
					st_next.quad = st_reg.acc;
				default:
					st_next.ptr = ptr_inc;
			endcase
		end

		// timer counts every cycle except a load, overflow sticky until reload
		if (op == MCUDP_OP_TIMERLD && !st_next.irq)
			st_next.ovf = 1'b0;
		else
		begin
			st_next.timer = st_reg.timer + 8'h01;           // RULE7
			if (st_reg.timer == 8'hFF)
				st_next.ovf = 1'b1;                         // RULE7
		end

		// serial register: swap wins over shifting or counting
		if (op == MCUDP_OP_SWAPSER && !st_next.irq)
		begin
			st_next.serial_shift_reg  = st_reg.acc;                      // RULE13
			st_next.acc  = st_reg.serial_shift_reg;                      // RULE13
			st_next.gate = st_reg.carry;                    // RULE12
		end
		else if (st_reg.en[MCUDP_EN_COUNTER])
		begin
			if (si_fall)
				st_next.serial_shift_reg = st_reg.serial_shift_reg - 4'h1;            // RULE15
		end
		else
			st_next.serial_shift_reg = {st_reg.serial_shift_reg[2:0], st_reg.si_sync[1]}; // RULE17

		// serial out, registered
		if (st_reg.en[MCUDP_EN_COUNTER])
			st_next.so = st_reg.en[MCUDP_EN_SO];            // RULE16
		else
			st_next.so = st_reg.en[MCUDP_EN_SO] & st_reg.serial_shift_reg[3]; // RULE21

		// interrupt acceptance drops the enable bit
		if (st_next.irq)
			st_next.en[MCUDP_EN_IRQ] = 1'b0;                // RULE19

		// host write loads latch and drops ready
		if (host_wr_fall)
		begin
			st_next.latch = st_reg.port_s2;                 // RULE10
			st_next.ready = 1'b0;                           // RULE24
		end
		else if (op == MCUDP_OP_QUADWR && !st_next.irq)
			st_next.ready = st_reg.acc[0];

		// reset values
		if (rst)
		begin
			st_next.ptr   = MCUDP_PTR_RESET;                // RULE25
			st_next.stack = '0;
			st_next.row   = '0;
			st_next.digit = 4'h0;
			st_next.acc   = 4'h0;
			st_next.carry = 1'b0;
			st_next.timer = MCUDP_TIMER_RESET;
			st_next.ovf   = 1'b0;
			st_next.en    = MCUDP_EN_RESET;
			st_next.serial_shift_reg   = 4'h0;
			st_next.gate  = MCUDP_GATE_RESET;               // RULE25
			st_next.latch = 8'h00;
			st_next.dout  = 4'h0;
			st_next.quad  = 4'h0;
			st_next.ready = 1'b0;
			st_next.so    = 1'b0;
			st_next.irq   = 1'b0;
			// general input and serial synchronisers start at idle pin levels so no false edge follows reset
			st_next.in_s1   = 4'hF;
			st_next.in_s2   = 4'hF;
			st_next.si_sync = 2'h3;
			st_next.si_prev = 1'b1;
			st_next.wr_prev = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk_sys)
	begin
		st_reg <= st_next;
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign instr_pointer     = st_reg.ptr;
	assign ram_row_select    = st_reg.row;
	assign ram_digit_select  = st_reg.digit;
	assign acc               = st_reg.acc;
	assign carry             = st_reg.carry;
	assign timer             = st_reg.timer;
	assign timer_ovf         = st_reg.ovf;
	assign irq_taken         = st_reg.irq;
	assign digit_output_port = st_reg.dout;
	assign clock_source_select = DUAL_CLK & st_reg.dout[0];      // RULE9
	assign serial_out        = st_reg.so;
	assign host_rd_n         = ~mcudp_strobe(st_reg.in_s2, 2'h1); // RULE8
	assign host_ready_out    = st_reg.ready;

	// --------------------------------------------------------------
	// port drivers
	// --------------------------------------------------------------
	// host read also presents the latch, whatever the drive enable says
	assign octal_io_port_out = st_reg.latch;
	assign octal_io_port_oe  = {8{st_reg.en[MCUDP_EN_DRIVE] | ~host_rd_n}}; // RULE20

	// --------------------------------------------------------------
	// quad port
	// --------------------------------------------------------------
	// bit 0 becomes the ready output under the host option
	assign quad_io_port_out  = HOST_BUS ? {st_reg.quad[3:1], st_reg.ready} : st_reg.quad; // RULE22
	assign quad_io_port_oe   = HOST_BUS ? 4'h1 : 4'hF;

	// --------------------------------------------------------------
	// serial clock
	// --------------------------------------------------------------
	// gated clock in shift mode, plain latch in counter mode
	assign serial_clock_pin  = st_reg.en[MCUDP_EN_COUNTER] ? st_reg.gate      // RULE16
		: (st_reg.gate & clk_sys);                                          // RULE18

endmodule

// ### verification/mcudp_checker.sv
// concurrent checks on the core datapath ports
// assumes one clock domain and the host strobe option in the bound instance
`timescale 1ns/10ps

module mcudp_checker
	import mcudp_pkg::*;
(
	input wire logic        clk_sys,          // cycle clock
	input wire logic        rst,              // sync reset
	input wire mcudp_op_e   op,               // operation
	input wire logic [7:0]  op_imm,           // immediate
	input wire logic [3:0]  ram_rdata,        // ram digit
	input wire logic        irq_req,          // interrupt request
	input wire logic [10:0] instr_pointer,    // program address
	input wire logic [3:0]  acc,              // accumulator
	input wire logic        carry,            // carry flag
	input wire logic [7:0]  timer,            // up timer
	input wire logic        timer_ovf,        // overflow flag
	input wire logic        irq_taken,        // interrupt accept
	input wire logic [3:0]  general_inputs,   // host strobes
	input wire logic [7:0]  octal_io_port_oe, // port enable
	input wire logic        serial_out,       // serial output
	input wire logic        host_rd_n,        // host read
	input wire logic        host_ready_out    // ready to host
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// --------------------------------------------------------------
	// pointer, stack and interrupt
	// --------------------------------------------------------------
	ptr_step_a: assert property (
		!irq_req && op inside {MCUDP_OP_NOP, MCUDP_OP_ADD} |=> instr_pointer == $past(instr_pointer) + 11'h001)
		else $error("pointer did not step by one");
	call_ret_a: assert property (
		!irq_req && op == MCUDP_OP_CALL ##1 !irq_req && op == MCUDP_OP_RET
		|=> instr_pointer == $past(instr_pointer, 2) + 11'h001)
		else $error("return missed the call address");
	irq_vector_a: assert property (
		irq_taken |-> instr_pointer == MCUDP_IRQ_VECTOR)
		else $error("interrupt not at vector");
	irq_once_a: assert property (
		irq_taken && op != MCUDP_OP_LOADEN |=> !irq_taken)
		else $error("interrupt enable not cleared");

	// --------------------------------------------------------------
	// arithmetic, timer, serial and port
	// --------------------------------------------------------------
	add_carry_a: assert property (
		!irq_req && op == MCUDP_OP_ADD |=> {carry, acc} == 5'($past(acc)) + 5'($past(ram_rdata)))
		else $error("adder sum or carry wrong");
	timer_wrap_a: assert property (
		timer == 8'hFF && op != MCUDP_OP_TIMERLD |=> timer == 8'h00 && timer_ovf)
		else $error("timer wrap without overflow");
	serout_mode_a: assert property (
		!irq_req && op == MCUDP_OP_LOADEN && (op_imm[0] || !op_imm[3]) |-> ##2 serial_out == $past(op_imm[3], 2))
		else $error("serial output level wrong");
	port_drive_a: assert property (
		!irq_req && op == MCUDP_OP_LOADEN ##1 host_rd_n |-> octal_io_port_oe == {8{$past(op_imm[2])}})
		else $error("port drivers do not follow enable");
	host_read_a: assert property (
		!host_rd_n |-> octal_io_port_oe == 8'hFF)
		else $error("host read does not drive port");
	ready_clear_a: assert property (
		$fell(general_inputs[3]) && !general_inputs[2] |-> ##[1:5] !host_ready_out)
		else $error("host write left ready set");
endmodule

// ### verification/mcudp_host_model.sv
// host processor model on the octal port with select, read and write strobes
// assumes the bench resolves the port pins from both drivers
`timescale 1ns/10ps

module mcudp_host_model
(
	output logic [3:0]      host_lines, // [1] read, [2] select, [3] write, low
	output logic [7:0]      host_data,  // value put on pins
	output logic            host_drive, // high while driving pins
	input  wire logic [7:0] pins        // resolved pin levels
);
	initial
	begin
		host_lines = 4'hF;
		host_data  = 8'h00;
		host_drive = 1'b0;
	end

	// write: select first, data held around the rising strobe
	task automatic wr(input logic [7:0] d);
		host_data     = d;
		host_drive    = 1'b1;
		host_lines[2] = 1'b0;
		#75;
		host_lines[3] = 1'b0;
		#400;
		host_lines[3] = 1'b1;
		#100;
		host_drive    = 1'b0;
		#25;
		host_lines[2] = 1'b1;
	endtask

	// read: sample the pins at the end of the strobe
	task automatic rd(output logic [7:0] d);
		host_lines[2] = 1'b0;
		#75;
		host_lines[1] = 1'b0;
		#400;
		d             = pins;
		host_lines[1] = 1'b1;
		#25;
		host_lines[2] = 1'b1;
	endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench for the core datapath with the host strobe option
// assumes the checker and host model files are compiled before it
`timescale 1ns/10ps

module tb_top;
	import mcudp_pkg::*;
	logic        clk_sys, rst, irq_req, serial_in, carry, timer_ovf, irq_taken;
	logic        serial_out, serial_clock_pin, host_ready_out, ram_we, host_drive;
	mcudp_op_e   op;
	logic [10:0] op_target, instr_pointer;
	logic [7:0]  op_imm, timer, octal_io_port_out, octal_io_port_oe, host_data, pins;
	logic [7:0]  pin_last = 8'h00;
	logic [3:0]  ram_rdata, acc, ram_wdata, host_lines, ram_digit_select, digit_output_port;
	logic [3:0]  quad_io_port_out, quad_io_port_oe;
	logic [2:0]  ram_row_select;
	logic        clock_source_select, host_rd_n;
	int          n_fail = 0;
	int          check_count = 0;

	mcudp_core #(.HOST_BUS(1'b1), .DUAL_CLK(1'b1)) u_dut (
		.clk_sys(clk_sys), .rst(rst), .op(op), .op_target(op_target), .op_imm(op_imm),
		.ram_rdata(ram_rdata), .irq_req(irq_req), .instr_pointer(instr_pointer),
		.ram_row_select(ram_row_select), .ram_digit_select(ram_digit_select), .ram_we(ram_we),
		.ram_wdata(ram_wdata), .acc(acc), .carry(carry),
		.timer(timer), .timer_ovf(timer_ovf), .irq_taken(irq_taken), .general_inputs(host_lines),
		.octal_io_port_in(pins), .octal_io_port_out(octal_io_port_out), .octal_io_port_oe(octal_io_port_oe),
		.quad_io_port_in(4'h0), .quad_io_port_out(quad_io_port_out), .quad_io_port_oe(quad_io_port_oe),
		.digit_output_port(digit_output_port), .clock_source_select(clock_source_select),
		.serial_in(serial_in), .serial_out(serial_out),
		.serial_clock_pin(serial_clock_pin), .host_rd_n(host_rd_n), .host_ready_out(host_ready_out));
	mcudp_host_model u_host (.host_lines(host_lines), .host_data(host_data), .host_drive(host_drive), .pins(pins));

	// undriven port lines show the inverse of their last level
	assign pins = (octal_io_port_oe & octal_io_port_out)
		| (~octal_io_port_oe & (host_drive ? host_data : ~pin_last));
	always @(posedge clk_sys) pin_last <= pins;

	// clock and watchdog
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial
	begin
		#(3000 * 25);
		n_fail++;
		final_report();
	end

	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// op stands one cycle; results are looked at on return
	task automatic issue(input mcudp_op_e o, input logic [10:0] arg, input logic [3:0] rd);
		op        = o;
		op_target = arg;
		op_imm    = arg[7:0];
		ram_rdata = rd;
		@(posedge clk_sys);
		#2;
	endtask
	task automatic idle(input int n);
		op = MCUDP_OP_NOP;
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_alu_timer();
		issue(MCUDP_OP_LOADA, 11'h009, 4'h0);
		issue(MCUDP_OP_ADD, 11'h000, 4'h8);
		chk(16'({carry, acc}), 16'h0011);
		issue(MCUDP_OP_ADDC, 11'h000, 4'hE);
		chk(16'({carry, acc}), 16'h0010);
		issue(MCUDP_OP_LOADA, 11'h00E, 4'h0);
		issue(MCUDP_OP_TIMERLD, 11'h000, 4'hF);
		chk(16'(timer), 16'h00FE);
		idle(2);
		chk(16'({timer_ovf, timer}), 16'h0100);
	endtask
	task automatic t_stack_irq();
		logic [10:0] tgt [4] = '{11'h200, 11'h300, 11'h400, 11'h500};
		logic [10:0] back [4] = '{11'h401, 11'h301, 11'h201, 11'h201};
		issue(MCUDP_OP_JUMP, 11'h100, 4'h0);
		chk(16'(instr_pointer), 16'h0100);
		foreach (tgt[i])
		begin
			issue(MCUDP_OP_CALL, tgt[i], 4'h0);
			chk(16'(instr_pointer), 16'(tgt[i]));
		end
		foreach (back[i])
		begin
			issue(MCUDP_OP_RET, 11'h000, 4'h0);
			chk(16'(instr_pointer), 16'(back[i]));
		end
		issue(MCUDP_OP_LOADEN, 11'h002, 4'h0);
		issue(MCUDP_OP_JUMP, 11'h050, 4'h0);
		irq_req = 1'b1;
		issue(MCUDP_OP_NOP, 11'h000, 4'h0);
		chk(16'({irq_taken, instr_pointer}), 16'h08FF);
		issue(MCUDP_OP_NOP, 11'h000, 4'h0);
		chk(16'({irq_taken, instr_pointer}), 16'h0100);
		irq_req = 1'b0;
		issue(MCUDP_OP_RET, 11'h000, 4'h0);
		chk(16'(instr_pointer), 16'h0051);
		idle(1);
	endtask
	task automatic t_port_host();
		logic [7:0] d;
		issue(MCUDP_OP_LATCHROM, 11'h03C, 4'h0);
		issue(MCUDP_OP_LOADEN, 11'h004, 4'h0);
		chk(16'({octal_io_port_oe, octal_io_port_out}), 16'hFF3C);
		idle(3);
		op = MCUDP_OP_PORTRD_LO;
		#1;
		chk(16'({ram_we, ram_wdata}), 16'h0013);
		@(posedge clk_sys);
		#2;
		chk(16'(acc), 16'h000C);
		issue(MCUDP_OP_LOADA, 11'h001, 4'h0);
		issue(MCUDP_OP_LOADEN, 11'h000, 4'h0);
		chk(16'(octal_io_port_oe), 16'h0000);
		issue(MCUDP_OP_QUADWR, 11'h000, 4'h0);
		chk(16'(host_ready_out), 16'h0001);
		idle(1);
		u_host.wr(8'hA5);
		idle(4);
		chk(16'({host_ready_out, octal_io_port_out}), 16'h00A5);
		fork
			u_host.rd(d);
			begin
				repeat (10) @(posedge clk_sys);
				#2;
				chk(16'(host_rd_n), 16'h0000);
			end
		join
		chk(16'(d), 16'h00A5);
		idle(1);
	endtask
	task automatic t_serial();
		issue(MCUDP_OP_LOADEN, 11'h001, 4'h0);
		issue(MCUDP_OP_LOADA, 11'h00F, 4'h0);
		issue(MCUDP_OP_ADD, 11'h000, 4'h0);
		issue(MCUDP_OP_SWAPSER, 11'h000, 4'h0);
		idle(1);
		chk(16'({serial_clock_pin, serial_out}), 16'h0000);
		// link clock of 200 ns, changing just after a cycle edge
		repeat (3)
		begin
			#100 serial_in = 1'b0;
			#100 serial_in = 1'b1;
		end
		idle(6);
		issue(MCUDP_OP_SWAPSER, 11'h000, 4'h0);
		chk(16'(acc), 16'h000C);
		issue(MCUDP_OP_LOADEN, 11'h009, 4'h0);
		issue(MCUDP_OP_ADD, 11'h000, 4'h4);
		chk(16'({serial_clock_pin, serial_out}), 16'h0001);
		issue(MCUDP_OP_LOADEN, 11'h008, 4'h0);
		idle(8);
		chk(16'(serial_out), 16'h0001);
		issue(MCUDP_OP_SWAPSER, 11'h000, 4'h0);
		chk(16'(acc), 16'h000F);
		idle(1);
		chk(16'(serial_clock_pin), 16'h0001);
		#13;
		chk(16'(serial_clock_pin), 16'h0000);
		@(posedge clk_sys);
		#2;
		issue(MCUDP_OP_LOADEN, 11'h000, 4'h0);
		idle(2);
		chk(16'(serial_out), 16'h0000);
		issue(MCUDP_OP_SWAPSER, 11'h000, 4'h0);
		chk(16'(acc), 16'h000F);
		idle(1);
	endtask

	task automatic t_ram_io();
		issue(MCUDP_OP_QUADWR, 11'h000, 4'h0);
		chk(16'({quad_io_port_oe, quad_io_port_out}), 16'h001F);
		issue(MCUDP_OP_LATCHLO, 11'h000, 4'h3);
		chk(16'(octal_io_port_out), 16'h003F);
		issue(MCUDP_OP_LATCHHI, 11'h000, 4'h3);
		chk(16'(octal_io_port_out), 16'h00F3);
		issue(MCUDP_OP_AND, 11'h000, 4'h6);
		issue(MCUDP_OP_XOR, 11'h000, 4'h3);
		chk(16'(acc), 16'h0005);
		issue(MCUDP_OP_LOADROW, 11'h005, 4'h0);
		issue(MCUDP_OP_LOADDIG, 11'h00B, 4'h0);
		chk(16'({ram_row_select, ram_digit_select}), 16'h005B);
		issue(MCUDP_OP_DIGOUT, 11'h000, 4'h0);
		chk(16'({clock_source_select, digit_output_port}), 16'h001B);
	endtask

	// main sequence
	initial
	begin
		rst       = 1'b1;
		op        = MCUDP_OP_NOP;
		op_target = 11'h000;
		op_imm    = 8'h00;
		ram_rdata = 4'h0;
		irq_req   = 1'b0;
		serial_in = 1'b1;
		repeat (12) @(posedge clk_sys);
		#2;
		chk(16'({instr_pointer, acc}), 16'h0000);
		chk(16'({timer, carry, host_ready_out, serial_clock_pin}), 16'h0001);
		rst = 1'b0;
		idle(1);
		t_alu_timer();
		t_stack_irq();
		t_port_host();
		t_serial();
		t_ram_io();
		final_report();
	end
endmodule

bind mcudp_core mcudp_checker u_chk (
	.clk_sys(clk_sys), .rst(rst), .op(op), .op_imm(op_imm), .ram_rdata(ram_rdata), .irq_req(irq_req),
	.instr_pointer(instr_pointer), .acc(acc), .carry(carry), .timer(timer), .timer_ovf(timer_ovf),
	.irq_taken(irq_taken), .general_inputs(general_inputs), .octal_io_port_oe(octal_io_port_oe),
	.serial_out(serial_out), .host_rd_n(host_rd_n), .host_ready_out(host_ready_out));
